// ==== rtl/cil_map.vh ====
`ifndef CIL_MAP_VH
`define CIL_MAP_VH
// ***************************************************
// register offsets and reset values
// ***************************************************
`define CIL_ADDR_VLIM      8'h02
`define CIL_ADDR_CURRENT_LIMIT_PIN      8'h03
`define CIL_ADDR_PRETERM   8'h04
`define CIL_RST_VLIM       8'h84
`define CIL_RST_CURRENT_LIMIT_PIN       8'h39
`define CIL_RST_PRETERM    8'h22
// ***************************************************
// field positions
// ***************************************************
`define CIL_VLIM_AUTORST   7
`define CIL_VLIM_DISCHG    6
`define CIL_VLIM_OOA_DIS   5
`define CIL_CURRENT_LIMIT_PIN_FORCE_OPT 7
`define CIL_CURRENT_LIMIT_PIN_FORCE_DET 6
`define CIL_CURRENT_LIMIT_PIN_OPT_EN    5
// ***************************************************
// setpoint scaling, millivolt or milliamp units
// ***************************************************
`define CIL_VFLOOR_BASE    16'h0F3C
`define CIL_VFLOOR_STEP    16'h0064
`define CIL_VFLOOR_MAXCODE 5'h10
`define CIL_ICEIL_BASE     16'h01F4
`define CIL_ICEIL_STEP     16'h0064
`define CIL_ICEIL_MAXCODE  5'h1C
`define CIL_TERMINATION_CURRENT_BASE     16'h0032
`define CIL_TERMINATION_CURRENT_STEP     16'h0032
`endif

// ==== rtl/cil_scale.v ====
`timescale 1ns/1ns
`include "cil_map.vh"
// ***************************************************
// code to setpoint: base plus step per code, clamped
// ***************************************************
module cil_scale #(
	parameter        CW   = 5,
	parameter [15:0] BASE = 16'h0000,
	parameter [15:0] STEP = 16'h0001,
	parameter [CW-1:0] MAXC = {CW{1'b1}}
) (
	input  wire [CW-1:0] code_in,
	output wire [15:0]   value_out
);
	wire [CW-1:0] clamped;
	wire [31:0]   prod;
	// clamp before multiply so the product never runs past range
	assign clamped   = (code_in > MAXC) ? MAXC : code_in;
	assign prod      = {{(32-CW){1'b0}}, clamped} * {16'h0000, STEP};
	assign value_out = BASE + prod[15:0];
endmodule

// ==== rtl/cil_min4.v ====
`timescale 1ns/1ns
// ***************************************************
// smallest of four current limits
// ***************************************************
module cil_min4 (
	input  wire [15:0] a_in,
	input  wire [15:0] b_in,
	input  wire [15:0] c_in,
	input  wire [15:0] d_in,
	output wire [15:0] min_out
);
	wire [15:0] ab;
	wire [15:0] cd;
	// two-level tree keeps the compare depth short
	assign ab      = (a_in < b_in) ? a_in : b_in;
	assign cd      = (c_in < d_in) ? c_in : d_in;
	assign min_out = (ab < cd) ? ab : cd;
endmodule

// ==== rtl/cil_regs.v ====
`timescale 1ns/1ns
`include "cil_map.vh"
module cil_regs (
	input  wire        clock_in,
	input  wire        rst_b_in,
	input  wire        wr_en_in,
	input  wire        rd_en_in,
	input  wire [7:0]  addr_in,
	input  wire [7:0]  wdata_in,
	input  wire        reg_reset_in,
	input  wire        wdog_expire_in,
	input  wire        plugin_detect_done_in,
	input  wire        optimizer_started_in,
	input  wire        source_detect_done_in,
	input  wire [15:0] optimizer_current_result_in,
	input  wire [15:0] current_limit_pin_in,
	input  wire [15:0] source_select_limit_in,
	output reg  [7:0]  rdata_out,
	output reg         rvalid_out,
	output reg         vfloor_autorestore_en_out,
	output reg         battery_discharge_load_en_out,
	output reg         light_load_audio_skip_dis_out,
	output reg  [15:0] input_voltage_floor_mv_out,
	output reg         optimizer_force_start_out,
	output reg         source_detect_force_out,
	output reg         optimizer_enable_out,
	output reg  [15:0] input_current_ceiling_ma_out,
	output reg  [15:0] effective_current_limit_ma_out,
	output reg  [15:0] precharge_current_ma_out,
	output reg  [15:0] termination_current_ma_out
);
	// ***************************************************
	// reset synchroniser
	// ***************************************************
	reg        rst_s1_q;
	reg        rst_s2_q;
	wire       rst_b;

	// two flops so release never lands near a clock edge
	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_b = rst_s2_q;

	// ***************************************************
	// register storage
	// ***************************************************
	reg  [7:0]  vlim_q;
	reg  [7:0]  vlim_d;
	reg  [7:0]  current_limit_pin_q;
	reg  [7:0]  current_limit_pin_d;
	reg  [7:0]  pt_q;
	reg  [7:0]  pt_d;
	reg         upd_q;
	wire        wr_vlim;
	wire        wr_current_limit_pin;
	wire        wr_pt;
	wire [7:0]  rst_v;
	wire [7:0]  rst_i;

	// address decode for writes
	assign wr_vlim = wr_en_in && (addr_in == `CIL_ADDR_VLIM);
	assign wr_current_limit_pin = wr_en_in && (addr_in == `CIL_ADDR_CURRENT_LIMIT_PIN);
	assign wr_pt   = wr_en_in && (addr_in == `CIL_ADDR_PRETERM);
	assign rst_v   = `CIL_RST_VLIM;
	assign rst_i   = `CIL_RST_CURRENT_LIMIT_PIN;

	// next-state: writes, then resets and hardware events
	always @* begin
		vlim_d = vlim_q;
		current_limit_pin_d = current_limit_pin_q;
		pt_d   = pt_q;
		if (wr_vlim) begin
			vlim_d = wdata_in;
		end
		if (wr_current_limit_pin) begin
			current_limit_pin_d = wdata_in;
		end
		if (wr_pt) begin
			pt_d = wdata_in;
		end
		// plug-in restore only when enabled; else field untouched
		if (plugin_detect_done_in &&
		    vlim_q[`CIL_VLIM_AUTORST]) begin
			vlim_d[4:0] = rst_v[4:0];
		end
		// hardware clear: optimizer has started
		if (optimizer_started_in && current_limit_pin_q[`CIL_CURRENT_LIMIT_PIN_FORCE_OPT]) begin
			current_limit_pin_d[`CIL_CURRENT_LIMIT_PIN_FORCE_OPT] = 1'b0;
		end
		// force detect returns to 0 when the cycle ends
		if (source_detect_done_in) begin
			current_limit_pin_d[`CIL_CURRENT_LIMIT_PIN_FORCE_DET] = 1'b0;
		end
		// watchdog keeps bits 5..0 of both limit registers
		if (wdog_expire_in) begin
			vlim_d[7:6] = rst_v[7:6];
			current_limit_pin_d[7:6] = rst_i[7:6];
			pt_d        = `CIL_RST_PRETERM;
		end
		// register reset reloads the reset value of all three registers
		if (reg_reset_in) begin
			vlim_d = `CIL_RST_VLIM;
			current_limit_pin_d = `CIL_RST_CURRENT_LIMIT_PIN;
			pt_d   = `CIL_RST_PRETERM;
		end
	end

	// storage flops; upd_q marks a completed change
	always @(posedge clock_in or negedge rst_b) begin
		if (!rst_b) begin
			vlim_q <= `CIL_RST_VLIM;
			current_limit_pin_q <= `CIL_RST_CURRENT_LIMIT_PIN;
			pt_q   <= `CIL_RST_PRETERM;
			upd_q  <= 1'b1;
		end else begin
			vlim_q <= vlim_d;
			current_limit_pin_q <= current_limit_pin_d;
			pt_q   <= pt_d;
			upd_q  <= (vlim_d != vlim_q) || (current_limit_pin_d != current_limit_pin_q) ||
			          (pt_d != pt_q);
		end
	end

	// ***************************************************
	// setpoint decode
	// ***************************************************
	wire [15:0] vfloor_mv;
	wire [15:0] iceil_ma;
	wire [15:0] ipre_ma;
	wire [15:0] termination_current_ma;
	wire [15:0] ieff_ma;

	// voltage floor, clamped at code 10h
	cil_scale #(
		.CW   (5),
		.BASE (`CIL_VFLOOR_BASE),
		.STEP (`CIL_VFLOOR_STEP),
		.MAXC (`CIL_VFLOOR_MAXCODE)
	) u_vfloor (
		.code_in   (vlim_q[4:0]),
		.value_out (vfloor_mv)
	);

	// input current ceiling, clamped at code 1Ch
	cil_scale #(
		.CW   (5),
		.BASE (`CIL_ICEIL_BASE),
		.STEP (`CIL_ICEIL_STEP),
		.MAXC (`CIL_ICEIL_MAXCODE)
	) u_iceil (
		.code_in   (current_limit_pin_q[4:0]),
		.value_out (iceil_ma)
	);

	// precharge current from the upper nibble
	cil_scale #(
		.CW   (4),
		.BASE (`CIL_TERMINATION_CURRENT_BASE),
		.STEP (`CIL_TERMINATION_CURRENT_STEP),
		.MAXC (4'hF)
	) u_ipre (
		.code_in   (pt_q[7:4]),
		.value_out (ipre_ma)
	);

	// termination current from the lower nibble
	cil_scale #(
		.CW   (4),
		.BASE (`CIL_TERMINATION_CURRENT_BASE),
		.STEP (`CIL_TERMINATION_CURRENT_STEP),
		.MAXC (4'hF)
	) u_termination_current (
		.code_in   (pt_q[3:0]),
		.value_out (termination_current_ma)
	);

	// lowest of register, optimizer, pin and source limits
	cil_min4 u_min (
		.a_in    (iceil_ma),
		.b_in    (optimizer_current_result_in),
		.c_in    (current_limit_pin_in),
		.d_in    (source_select_limit_in),
		.min_out (ieff_ma)
	);

	// ***************************************************
	// outputs and read port
	// ***************************************************
	// setpoints refresh only after a completed change
	always @(posedge clock_in or negedge rst_b) begin
		if (!rst_b) begin
			input_voltage_floor_mv_out   <= 16'h0000;
			input_current_ceiling_ma_out <= 16'h0000;
			precharge_current_ma_out     <= 16'h0000;
			termination_current_ma_out   <= 16'h0000;
		end else if (upd_q) begin
			input_voltage_floor_mv_out   <= vfloor_mv;
			input_current_ceiling_ma_out <= iceil_ma;
			precharge_current_ma_out     <= ipre_ma;
			termination_current_ma_out   <= termination_current_ma;
		end
	end

	// control bits and the live minimum
	always @(posedge clock_in or negedge rst_b) begin
		if (!rst_b) begin
			vfloor_autorestore_en_out      <= 1'b0;
			battery_discharge_load_en_out  <= 1'b0;
			light_load_audio_skip_dis_out  <= 1'b0;
			optimizer_force_start_out      <= 1'b0;
			source_detect_force_out        <= 1'b0;
			optimizer_enable_out           <= 1'b0;
			effective_current_limit_ma_out <= 16'h0000;
		end else begin
			vfloor_autorestore_en_out     <= vlim_q[`CIL_VLIM_AUTORST];
			battery_discharge_load_en_out <= vlim_q[`CIL_VLIM_DISCHG];
			light_load_audio_skip_dis_out <= vlim_q[`CIL_VLIM_OOA_DIS];
			// request reaches the optimizer only while enabled
			optimizer_force_start_out <= current_limit_pin_q[`CIL_CURRENT_LIMIT_PIN_FORCE_OPT] &&
			                             current_limit_pin_q[`CIL_CURRENT_LIMIT_PIN_OPT_EN];
			source_detect_force_out   <= current_limit_pin_q[`CIL_CURRENT_LIMIT_PIN_FORCE_DET];
			optimizer_enable_out      <= current_limit_pin_q[`CIL_CURRENT_LIMIT_PIN_OPT_EN];
			effective_current_limit_ma_out <= ieff_ma;
		end
	end

	// read data one cycle after the strobe; unmapped reads 00h
	always @(posedge clock_in or negedge rst_b) begin
		if (!rst_b) begin
			rdata_out  <= 8'h00;
			rvalid_out <= 1'b0;
		end else begin
			rvalid_out <= rd_en_in;
			if (!rd_en_in) begin
				rdata_out <= rdata_out;
			end else if (addr_in == `CIL_ADDR_VLIM) begin
				rdata_out <= vlim_q;
			end else if (addr_in == `CIL_ADDR_CURRENT_LIMIT_PIN) begin
				rdata_out <= current_limit_pin_q;
			end else if (addr_in == `CIL_ADDR_PRETERM) begin
				rdata_out <= pt_q;
			end else begin
				rdata_out <= 8'h00;
			end
		end
	end
endmodule

// ==== sim/cil_chk.sv ====
`timescale 1ns/1ns
// ****
// port-level checks of the limit register bank
// ****
module cil_chk (
	input wire        clock_in,
	input wire        rst_b_in,
	input wire        wr_en_in,
	input wire        rd_en_in,
	input wire [7:0]  addr_in,
	input wire [7:0]  wdata_in,
	input wire        reg_reset_in,
	input wire        wdog_expire_in,
	input wire        plugin_detect_done_in,
	input wire        optimizer_started_in,
	input wire        rvalid_out,
	input wire        vfloor_autorestore_en_out,
	input wire        battery_discharge_load_en_out,
	input wire        light_load_audio_skip_dis_out,
	input wire        optimizer_force_start_out,
	input wire        source_detect_force_out,
	input wire        optimizer_enable_out,
	input wire [15:0] input_voltage_floor_mv_out,
	input wire [15:0] input_current_ceiling_ma_out
);
	// decode of the byte on the write port; events would override it
	wire [4:0]  c = wdata_in[4:0];
	wire [15:0] v_exp = 16'h0F3C + 16'h0064 *
		((c > 5'h10) ? 16'h0010 : {11'h000, c});
	wire [15:0] i_exp = 16'h01F4 + 16'h0064 *
		((c > 5'h1C) ? 16'h001C : {11'h000, c});
	wire q = !reg_reset_in && !wdog_expire_in && !plugin_detect_done_in;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_w2; wr_en_in && q && addr_in == 8'h02; endsequence
	sequence s_w3; wr_en_in && q && addr_in == 8'h03; endsequence
	sequence s_def;
		vfloor_autorestore_en_out && optimizer_enable_out &&
		!battery_discharge_load_en_out && !light_load_audio_skip_dis_out;
	endsequence
	property p_rv; rd_en_in |=> rvalid_out; endproperty
	a_rv: assert property (p_rv) else $error("read not answered");
	property p_nrv; !rd_en_in |=> !rvalid_out; endproperty
	a_nrv: assert property (p_nrv) else $error("stray rvalid");
	property p_dis;
		s_w2 |-> ##2 battery_discharge_load_en_out == $past(wdata_in[6], 2);
	endproperty
	a_dis: assert property (p_dis) else $error("load enable wrong");
	property p_ooa;
		s_w2 |-> ##2 light_load_audio_skip_dis_out == $past(wdata_in[5], 2);
	endproperty
	a_ooa: assert property (p_ooa) else $error("audio skip wrong");
	property p_vf; s_w2 |-> ##3 input_voltage_floor_mv_out == $past(v_exp, 3);
	endproperty
	a_vf: assert property (p_vf) else $error("voltage floor wrong");
	property p_ic;
		s_w3 |-> ##3 input_current_ceiling_ma_out == $past(i_exp, 3);
	endproperty
	a_ic: assert property (p_ic) else $error("ceiling wrong");
	property p_en; s_w3 |-> ##2 optimizer_enable_out == $past(wdata_in[5], 2);
	endproperty
	a_en: assert property (p_en) else $error("enable wrong");
	// start request reaches the optimizer only with enable in the same byte
	property p_fo;
		s_w3 && !optimizer_started_in |-> ##2
		optimizer_force_start_out == $past(wdata_in[7] && wdata_in[5], 2);
	endproperty
	a_fo: assert property (p_fo) else $error("force w/o enable");
	property p_wd;
		wdog_expire_in && !reg_reset_in |-> ##2 (vfloor_autorestore_en_out &&
		!battery_discharge_load_en_out && !source_detect_force_out);
	endproperty
	a_wd: assert property (p_wd) else $error("watchdog clear wrong");
	property p_rr;
		reg_reset_in |-> ##2 s_def ##1 (input_voltage_floor_mv_out == 16'h10CC
		&& input_current_ceiling_ma_out == 16'h0BB8);
	endproperty
	a_rr: assert property (p_rr) else $error("reset defaults wrong");
endmodule
bind cil_regs cil_chk u_chk (.*);

// ==== sim/cil_host.sv ====
`timescale 1ns/1ns
// ****
// host on the parallel register bus, byte accesses
// ****
module cil_host (
	input  wire        clock_in,
	input  wire  [7:0] rdata_in,
	output logic       wr_en_out,
	output logic       rd_en_out,
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out
);
	// idle bus at time zero
	initial begin
		wr_en_out = 1'b0;
		rd_en_out = 1'b0;
		addr_out  = 8'h00;
		wdata_out = 8'h00;
	end
	// one-cycle strobe; released lines show inverse, never the old value
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clock_in);
		wr_en_out <= 1'b1;
		addr_out  <= a;
		wdata_out <= d;
		@(posedge clock_in);
		wr_en_out <= 1'b0;
		addr_out  <= ~a;
		wdata_out <= ~d;
	endtask
	// data is registered and stands at the edge after the strobe edge
	task rd(input [7:0] a, output [7:0] d);
		@(posedge clock_in);
		rd_en_out <= 1'b1;
		addr_out  <= a;
		@(posedge clock_in);
		rd_en_out <= 1'b0;
		addr_out  <= ~a;
		@(posedge clock_in);
		d = rdata_in;
	endtask
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ns
module tb;
	logic        clock_in, rst_b_in;
	wire         wr_en_in, rd_en_in, rvalid_out;
	wire  [7:0]  addr_in, wdata_in, rdata_out;
	logic [4:0]  ev;
	wire         reg_reset_in, wdog_expire_in, plugin_detect_done_in;
	wire         optimizer_started_in, source_detect_done_in;
	logic [15:0] optimizer_current_result_in, current_limit_pin_in;
	logic [15:0] source_select_limit_in;
	wire         vfloor_autorestore_en_out, battery_discharge_load_en_out;
	wire         light_load_audio_skip_dis_out, optimizer_force_start_out;
	wire         source_detect_force_out, optimizer_enable_out;
	wire  [15:0] input_voltage_floor_mv_out, input_current_ceiling_ma_out;
	wire  [15:0] effective_current_limit_ma_out, precharge_current_ma_out;
	wire  [15:0] termination_current_ma_out;
	int          errors, total_checks, k;
	logic [7:0]  d;
	assign {source_detect_done_in, optimizer_started_in,
		plugin_detect_done_in, wdog_expire_in, reg_reset_in} = ev;
	cil_regs dut (.*);
	cil_host h (
		.clock_in  (clock_in),
		.rdata_in  (rdata_out),
		.wr_en_out (wr_en_in),
		.rd_en_out (rd_en_in),
		.addr_out  (addr_in),
		.wdata_out (wdata_in)
	);
	task chk(input [15:0] got, input [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task rc(input [7:0] a, input [7:0] e);
		h.rd(a, d);
		chk({8'h00, d}, {8'h00, e});
	endtask
	// event bit 0 reg reset, 1 watchdog, 2 plug-in, 3 opt start, 4 detect
	task pulse(input int i);
		@(posedge clock_in);
		ev <= 5'h01 << i;
		@(posedge clock_in);
		ev <= 5'h00;
		repeat (3) @(posedge clock_in);
	endtask
	task test_done;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	function [15:0] dec(input [4:0] c, input [4:0] m, input [15:0] b);
		dec = b + 16'h0064 * ((c > m) ? {11'h000, m} : {11'h000, c});
	endfunction
	// clock and hang guard
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	initial begin
		#200000;
		errors++;
		test_done;
	end
	// ****
	// main sequence
	// ****
	initial begin
		rst_b_in = 1'b0;
		ev = 5'h00;
		optimizer_current_result_in = 16'hFFFF;
		current_limit_pin_in = 16'hFFFF;
		source_select_limit_in = 16'hFFFF;
		repeat (6) @(posedge clock_in);
		rst_b_in <= 1'b1;
		repeat (4) @(posedge clock_in);
		rc(8'h02, 8'h84);
		rc(8'h03, 8'h39);
		rc(8'h04, 8'h22);
		chk(input_voltage_floor_mv_out, 16'h10CC);
		chk(input_current_ceiling_ma_out, 16'h0BB8);
		chk(termination_current_ma_out, 16'h0096);
		h.wr(8'h05, 8'hFF);
		rc(8'h05, 8'h00);
		// every code, clamp edges included, with the option bits toggling
		for (k = 0; k < 32; k++) begin
			h.wr(8'h02, {1'b0, k[0], k[1], k[4:0]});
			h.wr(8'h03, {2'b00, k[0], k[4:0]});
			h.wr(8'h04, {k[3:0], ~k[3:0]});
			repeat (4) @(posedge clock_in);
			chk(input_voltage_floor_mv_out, dec(k[4:0], 5'h10, 16'h0F3C));
			chk(effective_current_limit_ma_out, dec(k[4:0], 5'h1C, 16'h01F4));
			chk(precharge_current_ma_out, 16'h0032 * {12'h000, k[3:0]} + 16'h0032);
			chk(termination_current_ma_out, 16'h0032 * {12'h000, ~k[3:0]} + 16'h0032);
			rc(8'h02, {1'b0, k[0], k[1], k[4:0]});
		end
		// each outside limit in turn is the smallest
		for (k = 0; k < 3; k++) begin
			optimizer_current_result_in <= (k == 0) ? 16'h0300 : 16'h0C00;
			current_limit_pin_in <= (k == 1) ? 16'h0200 : 16'h0B00;
			source_select_limit_in <= (k == 2) ? 16'h0100 : 16'h0A00;
			repeat (5) @(posedge clock_in);
			chk(effective_current_limit_ma_out, 16'h0300 - 16'h0100 * k[15:0]);
		end
		h.wr(8'h02, 8'hA7);
		pulse(2);
		rc(8'h02, 8'hA4);
		h.wr(8'h02, 8'h27);
		pulse(2);
		rc(8'h02, 8'h27);
		h.wr(8'h02, 8'h67);
		h.wr(8'h03, 8'h65);
		h.wr(8'h04, 8'h5A);
		pulse(1);
		rc(8'h02, 8'hA7);
		rc(8'h03, 8'h25);
		rc(8'h04, 8'h22);
		h.wr(8'h03, 8'h85);
		repeat (3) @(posedge clock_in);
		chk({15'h0000, optimizer_force_start_out}, 16'h0000);
		h.wr(8'h03, 8'hA5);
		repeat (3) @(posedge clock_in);
		chk({15'h0000, optimizer_force_start_out}, 16'h0001);
		pulse(3);
		rc(8'h03, 8'h25);
		h.wr(8'h03, 8'h45);
		repeat (3) @(posedge clock_in);
		chk({15'h0000, source_detect_force_out}, 16'h0001);
		pulse(4);
		rc(8'h03, 8'h05);
		h.wr(8'h04, 8'h11);
		pulse(0);
		rc(8'h02, 8'h84);
		rc(8'h03, 8'h39);
		rc(8'h04, 8'h22);
		test_done;
	end
endmodule
